// >>> hdl/pps_top.sv
// Behaviour
// RULE1 - port_a: eight bits, per-bit direction
// RULE2 - Reset clears every direction bit to input
// RULE3 - Upper PWM replaces port_a bits 0-3
// RULE4 - port_b low five bits bidirectional
// RULE5 - port_b upper three inputs feed comparator 1-3
// RULE6 - port_c eight bits, per-bit direction
// RULE7 - port_d bits 0-1 bidirectional
// RULE8 - port_d 2-5 inputs; 2,3 timer clocks
// RULE9 - port_d 4,5 external interrupts; 5 comparator
// RULE10 - port_e 0,1 bidirectional or serial out/clock
// RULE11 - port_e bit 2 input, comparator and serial
// RULE12 - port_g open-drain outputs shared with PWM
// RULE13 - port_f 2-5 push-pull shared with OSD colours
// RULE14 - Input bit undriven; output drives latch
`timescale 1ns/1ps
module pps_top (
  input  wire logic           clk_sys,          // 20 MHz system clock
  input  wire logic           reset_n,          // Sync reset, active low
  input  wire pps_pkg::pps_wr_t wr,             // Latch/direction write
  input  wire logic [7:0]     port_a_i,         // port_a pin levels
  output logic [7:0]          port_a_o,         // port_a drive values
  output logic [7:0]          port_a_oe,        // port_a drive enables
  output logic [7:0]          port_a_rd,        // port_a read-back
  input  wire logic [7:0]     port_b_i,         // port_b pin levels
  output logic [4:0]          port_b_o,         // port_b[4:0] drive values
  output logic [4:0]          port_b_oe,        // port_b[4:0] drive enables
  output logic [7:0]          port_b_rd,        // port_b read-back
  input  wire logic [7:0]     port_c_i,         // port_c pin levels
  output logic [7:0]          port_c_o,         // port_c drive values
  output logic [7:0]          port_c_oe,        // port_c drive enables
  output logic [7:0]          port_c_rd,        // port_c read-back
  input  wire logic [5:0]     port_d_i,         // port_d pin levels
  output logic [1:0]          port_d_o,         // port_d[1:0] drive values
  output logic [1:0]          port_d_oe,        // port_d[1:0] drive enables
  output logic [5:0]          port_d_rd,        // port_d read-back
  input  wire logic [2:0]     port_e_i,         // port_e pin levels
  output logic [1:0]          port_e_o,         // port_e[1:0] drive values
  output logic [1:0]          port_e_oe,        // port_e[1:0] drive enables
  output logic [2:0]          port_e_rd,        // port_e read-back
  output logic [3:0]          port_f_o,         // port_f[5:2] push-pull
  output logic [3:0]          port_g_o,         // port_g open-drain level
  output logic [3:0]          port_g_oe,        // port_g pull-low enables
  input  wire logic           upper_pwm_en,     // Upper PWM owns port_a[3:0]
  input  wire logic [3:0]     upper_pwm_outputs, // Upper PWM levels
  input  wire logic [3:0]     lower_pwm_en,     // Per-bit PWM owns port_g
  input  wire logic [3:0]     lower_pwm_outputs, // Lower PWM levels
  input  wire logic           osd_en,           // OSD owns port_f[5:2]
  input  wire logic [3:0]     osd_color_outputs, // R, G, B, OUT
  input  wire logic           serial_en,        // Serial owns port_e[1:0]
  input  wire logic           serial_out_val,   // Serial data to send
  input  wire logic           serial_clk_val,   // Serial clock to send
  output logic                serial_in_pin,    // Serial data received
  output logic [4:0]          analog_cmp_inputs, // Comparator inputs 1-5
  output logic [1:0]          timer_ext_clk,    // Timers 2 and 3 clocks
  output logic                ext_irq_one,      // External interrupt 1
  output logic                ext_irq_two       // External interrupt 2
);

  logic                     sel_a;
  logic                     sel_b;
  logic                     sel_c;
  logic                     sel_d;
  logic                     sel_e;
  logic                     sel_f;
  logic                     sel_g;
  logic [pps_pkg::BIDIR_W-1:0] we_flat;
  logic [pps_pkg::BIDIR_W-1:0] wdat_flat;
  logic [pps_pkg::BIDIR_W-1:0] alt_en_flat;
  logic [pps_pkg::BIDIR_W-1:0] alt_val_flat;
  logic [pps_pkg::BIDIR_W-1:0] pin_i_flat;
  logic [pps_pkg::BIDIR_W-1:0] pin_o_flat;
  logic [pps_pkg::BIDIR_W-1:0] pin_oe_flat;
  logic [pps_pkg::BIDIR_W-1:0] rd_flat;
  logic [pps_pkg::IN_W-1:0]    in_raw;
  logic [pps_pkg::IN_W-1:0]    in_s1_reg;
  logic [pps_pkg::IN_W-1:0]    in_s2_reg;
  logic [3:0]               f_lat_reg;
  logic [3:0]               g_lat_reg;
  logic [3:0]               f_next;
  logic [3:0]               g_oe_next;

  // ------------------------------------------------------------
  // Write decode
  // ------------------------------------------------------------
  assign sel_a = wr.valid && (wr.port == pps_pkg::PPS_PORT_A);
  assign sel_b = wr.valid && (wr.port == pps_pkg::PPS_PORT_B);
  assign sel_c = wr.valid && (wr.port == pps_pkg::PPS_PORT_C);
  assign sel_d = wr.valid && (wr.port == pps_pkg::PPS_PORT_D);
  assign sel_e = wr.valid && (wr.port == pps_pkg::PPS_PORT_E);
  // Output-only ports have no direction, so direction writes are ignored
  assign sel_f = wr.valid && !wr.is_dir && (wr.port == pps_pkg::PPS_PORT_F);
  assign sel_g = wr.valid && !wr.is_dir && (wr.port == pps_pkg::PPS_PORT_G);

  assign we_flat   = {{2{sel_e}}, {2{sel_d}}, {8{sel_c}}, {5{sel_b}}, {8{sel_a}}};
  assign wdat_flat = {wr.data[1:0], wr.data[1:0], wr.data, wr.data[4:0], wr.data};
  assign pin_i_flat = {port_e_i[1:0], port_d_i[1:0], port_c_i, port_b_i[4:0], port_a_i};

  // ------------------------------------------------------------
  // Alternate function routing
  // ------------------------------------------------------------
  assign alt_en_flat  = {{2{serial_en}}, 19'h00000, {4{upper_pwm_en}}};   // RULE3 RULE10
  assign alt_val_flat = {serial_clk_val, serial_out_val, 19'h00000,
                         upper_pwm_outputs};                              // RULE3 RULE10

  // One cell per bidirectional bit keeps all 25 bits identical
  generate
    for (genvar i = 0; i < pps_pkg::BIDIR_W; i++) begin : g_bit
      pps_bit u_bit (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .dir_we  (we_flat[i] && wr.is_dir),                  // RULE1 RULE4 RULE6 RULE7
        .dat_we  (we_flat[i] && !wr.is_dir),
        .wdat    (wdat_flat[i]),
        .alt_en  (alt_en_flat[i]),
        .alt_val (alt_val_flat[i]),
        .pin_i   (pin_i_flat[i]),
        .pin_o   (pin_o_flat[i]),
        .pin_oe  (pin_oe_flat[i]),
        .rd      (rd_flat[i])
      );
    end
  endgenerate

  assign port_a_o  = pin_o_flat[pps_pkg::A_LSB +: pps_pkg::A_W];
  assign port_a_oe = pin_oe_flat[pps_pkg::A_LSB +: pps_pkg::A_W];
  assign port_a_rd = rd_flat[pps_pkg::A_LSB +: pps_pkg::A_W];
  assign port_b_o  = pin_o_flat[pps_pkg::B_LSB +: pps_pkg::B_W];
  assign port_b_oe = pin_oe_flat[pps_pkg::B_LSB +: pps_pkg::B_W];
  assign port_c_o  = pin_o_flat[pps_pkg::C_LSB +: pps_pkg::C_W];
  assign port_c_oe = pin_oe_flat[pps_pkg::C_LSB +: pps_pkg::C_W];
  assign port_c_rd = rd_flat[pps_pkg::C_LSB +: pps_pkg::C_W];
  assign port_d_o  = pin_o_flat[pps_pkg::D_LSB +: pps_pkg::D_W];
  assign port_d_oe = pin_oe_flat[pps_pkg::D_LSB +: pps_pkg::D_W];
  assign port_e_o  = pin_o_flat[pps_pkg::E_LSB +: pps_pkg::E_W];
  assign port_e_oe = pin_oe_flat[pps_pkg::E_LSB +: pps_pkg::E_W];

  // ------------------------------------------------------------
  // Input-only bits
  // ------------------------------------------------------------
  assign in_raw = {port_e_i[2], port_d_i[5:2], port_b_i[7:5]};

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      in_s1_reg <= '0;
      in_s2_reg <= '0;
    end else begin
      in_s1_reg <= in_raw;
      in_s2_reg <= in_s1_reg;
    end
  end

  assign port_b_rd = {in_s2_reg[pps_pkg::IN_B_LSB +: 3],
                      rd_flat[pps_pkg::B_LSB +: pps_pkg::B_W]};          // RULE5
  assign port_d_rd = {in_s2_reg[pps_pkg::IN_D_LSB +: 4],
                      rd_flat[pps_pkg::D_LSB +: pps_pkg::D_W]};          // RULE8
  assign port_e_rd = {in_s2_reg[pps_pkg::IN_E_LSB],
                      rd_flat[pps_pkg::E_LSB +: pps_pkg::E_W]};          // RULE11
  assign analog_cmp_inputs = {in_s2_reg[pps_pkg::IN_E_LSB],
                              in_s2_reg[pps_pkg::IN_D_LSB + 3],
                              in_s2_reg[pps_pkg::IN_B_LSB +: 3]};        // RULE5 RULE9 RULE11
  assign timer_ext_clk = in_s2_reg[pps_pkg::IN_D_LSB +: 2];              // RULE8
  assign ext_irq_one   = in_s2_reg[pps_pkg::IN_D_LSB + 2];               // RULE9
  assign ext_irq_two   = in_s2_reg[pps_pkg::IN_D_LSB + 3];               // RULE9
  assign serial_in_pin = in_s2_reg[pps_pkg::IN_E_LSB];                   // RULE11

  // ------------------------------------------------------------
  // Output-only ports
  // ------------------------------------------------------------
  assign f_next    = osd_en ? osd_color_outputs : f_lat_reg;             // RULE13
  // Open drain: a low level is the only one actively driven
  assign g_oe_next = ~((lower_pwm_en & lower_pwm_outputs)
                     | (~lower_pwm_en & g_lat_reg));                     // RULE12

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      f_lat_reg <= pps_pkg::PORT_F_RST;
      g_lat_reg <= pps_pkg::PORT_G_RST;
      port_f_o  <= pps_pkg::PORT_F_RST;
      port_g_oe <= 4'h0;
    end else begin
      if (sel_f) f_lat_reg <= wr.data[3:0];
      if (sel_g) g_lat_reg <= wr.data[3:0];
      port_f_o  <= f_next;
      port_g_oe <= g_oe_next;
    end
  end

  assign port_g_o = 4'h0;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_pwm_route;
    @(posedge clk_sys) disable iff (!reset_n)
      upper_pwm_en |=> (port_a_oe[3:0] == 4'hF) && (port_a_o[3:0] == $past(upper_pwm_outputs));
  endproperty
  a_pwm_route: assert property (p_pwm_route) else $error("upper PWM not on port_a"); // RULE3

  property p_cmp_b;
    @(posedge clk_sys) disable iff (!reset_n)
      ($past(reset_n) && $past(reset_n, 2))
        |-> analog_cmp_inputs[2:0] == $past(port_b_i[7:5], 2);
  endproperty
  a_cmp_b: assert property (p_cmp_b) else $error("comparator 1-3 mismatch"); // RULE5

  property p_timer_clk;
    @(posedge clk_sys) disable iff (!reset_n)
      ($past(reset_n) && $past(reset_n, 2)) |-> timer_ext_clk == $past(port_d_i[3:2], 2);
  endproperty
  a_timer_clk: assert property (p_timer_clk) else $error("timer clock mismatch"); // RULE8

  property p_irq;
    @(posedge clk_sys) disable iff (!reset_n)
      ($past(reset_n) && $past(reset_n, 2)) |-> (ext_irq_one == $past(port_d_i[4], 2))
        && (ext_irq_two == $past(port_d_i[5], 2)) && (analog_cmp_inputs[3] == ext_irq_two);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt input mismatch"); // RULE9

  property p_serial_out;
    @(posedge clk_sys) disable iff (!reset_n)
      serial_en |=> port_e_oe == 2'h3 && port_e_o == $past({serial_clk_val, serial_out_val});
  endproperty
  a_serial_out: assert property (p_serial_out) else $error("serial pins not routed"); // RULE10

  property p_serial_in;
    @(posedge clk_sys) disable iff (!reset_n)
      ($past(reset_n) && $past(reset_n, 2)) |-> serial_in_pin == $past(port_e_i[2], 2)
        && analog_cmp_inputs[4] == serial_in_pin;
  endproperty
  a_serial_in: assert property (p_serial_in) else $error("serial input mismatch"); // RULE11

  property p_port_g;
    @(posedge clk_sys) disable iff (!reset_n)
      (lower_pwm_en[0] && !lower_pwm_outputs[0]) |=> port_g_oe[0];
  endproperty
  a_port_g: assert property (p_port_g) else $error("PWM low not pulled down"); // RULE12

  property p_osd;
    @(posedge clk_sys) disable iff (!reset_n)
      osd_en ##1 osd_en |-> port_f_o == $past(osd_color_outputs);
  endproperty
  a_osd: assert property (p_osd) else $error("OSD colour not on port_f"); // RULE13

  property p_a_dir;
    @(posedge clk_sys) disable iff (!reset_n)
      (sel_a && wr.is_dir && wr.data[7]) ##1 !(sel_a && wr.is_dir) |=> port_a_oe[7];
  endproperty
  a_a_dir: assert property (p_a_dir) else $error("port_a direction ignored"); // RULE1

endmodule : pps_top

// >>> hdl/pps_pkg.sv
package pps_pkg;

  // ----------------------------------------------------------------
  // Flattened bidirectional bit map
  // ----------------------------------------------------------------
  localparam int A_LSB   = 0;
  localparam int A_W     = 8;
  localparam int B_LSB   = 8;
  localparam int B_W     = 5;
  localparam int C_LSB   = 13;
  localparam int C_W     = 8;
  localparam int D_LSB   = 21;
  localparam int D_W     = 2;
  localparam int E_LSB   = 23;
  localparam int E_W     = 2;
  localparam int BIDIR_W = 25;

  // ----------------------------------------------------------------
  // Input-only bit map (synchronised vector)
  // ----------------------------------------------------------------
  localparam int IN_B_LSB = 0;   // port_b[7:5]
  localparam int IN_D_LSB = 3;   // port_d[5:2]
  localparam int IN_E_LSB = 7;   // port_e[2]
  localparam int IN_W     = 8;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic       DIR_RST   = 1'b0;
  localparam logic       DAT_RST   = 1'b0;
  localparam logic [3:0] PORT_F_RST = 4'h0;
  localparam logic [3:0] PORT_G_RST = 4'hF;
  localparam int         SYNC_STAGES = 2;

  typedef enum logic [2:0] {
    PPS_PORT_A,
    PPS_PORT_B,
    PPS_PORT_C,
    PPS_PORT_D,
    PPS_PORT_E,
    PPS_PORT_F,
    PPS_PORT_G
  } pps_port_t;

  typedef struct packed {
    logic      valid;
    logic      is_dir;
    pps_port_t port;
    logic [7:0] data;
  } pps_wr_t;

endpackage : pps_pkg

// >>> hdl/pps_bit.sv
`timescale 1ns/1ps
module pps_bit (
  input  wire logic clk_sys,   // System clock
  input  wire logic reset_n,   // Sync reset, active low
  input  wire logic dir_we,    // Direction write strobe
  input  wire logic dat_we,    // Data latch write strobe
  input  wire logic wdat,      // Write value
  input  wire logic alt_en,    // Alternate function owns pin
  input  wire logic alt_val,   // Alternate output level
  input  wire logic pin_i,     // Pin level
  output logic      pin_o,     // Pin drive value
  output logic      pin_oe,    // Pin drive enable
  output logic      rd         // Synchronised pin level
);

  logic dir_reg;
  logic dat_reg;
  logic s1_reg;
  logic s2_reg;
  logic oe_next;
  logic o_next;

  // ------------------------------------------------------------
  // Pin ownership
  // ------------------------------------------------------------
  assign oe_next = alt_en | dir_reg;                          // RULE14
  assign o_next  = alt_en ? alt_val : dat_reg;                // RULE14

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      dir_reg <= pps_pkg::DIR_RST;                            // RULE2
      dat_reg <= pps_pkg::DAT_RST;
      pin_oe  <= 1'b0;
      pin_o   <= 1'b0;
      s1_reg  <= 1'b0;
      s2_reg  <= 1'b0;
    end else begin
      if (dir_we) dir_reg <= wdat;
      if (dat_we) dat_reg <= wdat;
      pin_oe <= oe_next;
      pin_o  <= o_next;
      s1_reg <= pin_i;
      s2_reg <= s1_reg;
    end
  end

  assign rd = s2_reg;

  property p_dir_reset;
    @(posedge clk_sys) disable iff (1'b0)
      !reset_n |=> (!pin_oe ##1 (!reset_n || $past(alt_en) || !pin_oe));
  endproperty
  a_dir_reset: assert property (p_dir_reset) else $error("pin driven after reset"); // RULE2

  property p_in_undriven;
    @(posedge clk_sys) disable iff (!reset_n)
      (dir_we && !wdat && !alt_en) ##1 (!alt_en && !dir_we) |=> !pin_oe;
  endproperty
  a_in_undriven: assert property (p_in_undriven) else $error("input bit driven"); // RULE14

  property p_out_drives;
    @(posedge clk_sys) disable iff (!reset_n)
      (dat_we && !alt_en) ##1 (!alt_en && dir_reg)
        |=> (pin_oe && pin_o == $past(wdat, 2));
  endproperty
  a_out_drives: assert property (p_out_drives) else $error("output latch not on pin"); // RULE14

endmodule : pps_bit

// >>> test/pps_board.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Board side of one bidirectional port
// ----------------------------------------------------------------
module pps_board #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] oe,    // Chip drive enables
  input  wire logic [W-1:0] o,     // Chip drive values
  input  wire logic [W-1:0] ext,   // Level of the board driver
  output logic      [W-1:0] pin    // Resolved pin level
);
  // Board driver only wins where the chip lets go, so no contention
  assign pin = (oe & o) | (~oe & ext);
endmodule : pps_board

// >>> test/port_pin_sharing_bench.sv
`timescale 1ns/1ps
module port_pin_sharing_bench;
  // ----------------------------------------------------------------
  // Stimulus and wiring
  // ----------------------------------------------------------------
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  pps_pkg::pps_wr_t wr = '0;
  logic [7:0] ext_a = 8'h00, ext_b = 8'h00, ext_c = 8'h00;
  logic [5:0] ext_d = 6'h00;
  logic [2:0] ext_e = 3'h0;
  logic upper_pwm_en = 1'b0, osd_en = 1'b0, serial_en = 1'b0;
  logic serial_out_val = 1'b0, serial_clk_val = 1'b0;
  logic [3:0] upper_pwm_outputs = 4'h0, lower_pwm_en = 4'h0;
  logic [3:0] lower_pwm_outputs = 4'h0, osd_color_outputs = 4'h0;
  logic [7:0] port_a_o, port_a_oe, port_a_rd, port_b_rd, port_c_o, port_c_oe, port_c_rd;
  logic [7:0] pin_a, pin_c;
  logic [4:0] port_b_o, port_b_oe, pin_b, analog_cmp_inputs;
  logic [5:0] port_d_rd;
  logic [2:0] port_e_rd;
  logic [1:0] port_d_o, port_d_oe, port_e_o, port_e_oe, pin_d, pin_e, timer_ext_clk;
  logic [3:0] port_f_o, port_g_o, port_g_oe;
  logic serial_in_pin, ext_irq_one, ext_irq_two;
  int   error_cnt = 0;
  int   check_count = 0;

  always #25 clk_sys = ~clk_sys;

  pps_board #(.W(8)) bd_a (.oe(port_a_oe), .o(port_a_o), .ext(ext_a), .pin(pin_a));
  pps_board #(.W(5)) bd_b (.oe(port_b_oe), .o(port_b_o), .ext(ext_b[4:0]), .pin(pin_b));
  pps_board #(.W(8)) bd_c (.oe(port_c_oe), .o(port_c_o), .ext(ext_c), .pin(pin_c));
  pps_board #(.W(2)) bd_d (.oe(port_d_oe), .o(port_d_o), .ext(ext_d[1:0]), .pin(pin_d));
  pps_board #(.W(2)) bd_e (.oe(port_e_oe), .o(port_e_o), .ext(ext_e[1:0]), .pin(pin_e));

  pps_top dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .wr(wr),
    .port_a_i(pin_a), .port_a_o(port_a_o), .port_a_oe(port_a_oe), .port_a_rd(port_a_rd),
    .port_b_i({ext_b[7:5], pin_b}), .port_b_o(port_b_o), .port_b_oe(port_b_oe),
    .port_b_rd(port_b_rd),
    .port_c_i(pin_c), .port_c_o(port_c_o), .port_c_oe(port_c_oe), .port_c_rd(port_c_rd),
    .port_d_i({ext_d[5:2], pin_d}), .port_d_o(port_d_o), .port_d_oe(port_d_oe),
    .port_d_rd(port_d_rd),
    .port_e_i({ext_e[2], pin_e}), .port_e_o(port_e_o), .port_e_oe(port_e_oe),
    .port_e_rd(port_e_rd),
    .port_f_o(port_f_o), .port_g_o(port_g_o), .port_g_oe(port_g_oe),
    .upper_pwm_en(upper_pwm_en), .upper_pwm_outputs(upper_pwm_outputs),
    .lower_pwm_en(lower_pwm_en), .lower_pwm_outputs(lower_pwm_outputs),
    .osd_en(osd_en), .osd_color_outputs(osd_color_outputs),
    .serial_en(serial_en), .serial_out_val(serial_out_val), .serial_clk_val(serial_clk_val),
    .serial_in_pin(serial_in_pin), .analog_cmp_inputs(analog_cmp_inputs),
    .timer_ext_clk(timer_ext_clk), .ext_irq_one(ext_irq_one), .ext_irq_two(ext_irq_two)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : check

  // Back-to-back calls present one write per cycle
  task automatic wr_send(input logic is_dir, input pps_pkg::pps_port_t p, input logic [7:0] d);
    @(negedge clk_sys);
    wr = {1'b1, is_dir, p, d};
  endtask : wr_send

  task automatic wr_end(input int settle);
    @(negedge clk_sys);
    wr.valid = 1'b0;
    repeat (settle) @(negedge clk_sys);
  endtask : wr_end

  function automatic int wid(input pps_pkg::pps_port_t p);
    case (p)
      pps_pkg::PPS_PORT_A, pps_pkg::PPS_PORT_C: wid = 8;
      pps_pkg::PPS_PORT_B: wid = 5;
      default: wid = 2;
    endcase
  endfunction : wid

  // Packs {o, oe, rd} of one bidirectional port
  function automatic logic [23:0] obs(input pps_pkg::pps_port_t p);
    case (p)
      pps_pkg::PPS_PORT_A: obs = {port_a_o, port_a_oe, port_a_rd};
      pps_pkg::PPS_PORT_B: obs = {3'h0, port_b_o, 3'h0, port_b_oe, port_b_rd};
      pps_pkg::PPS_PORT_C: obs = {port_c_o, port_c_oe, port_c_rd};
      pps_pkg::PPS_PORT_D: obs = {6'h0, port_d_o, 6'h0, port_d_oe, 2'h0, port_d_rd};
      default: obs = {6'h0, port_e_o, 6'h0, port_e_oe, 5'h00, port_e_rd};
    endcase
  endfunction : obs

  task automatic set_ext(input pps_pkg::pps_port_t p, input logic [7:0] v);
    case (p)
      pps_pkg::PPS_PORT_A: ext_a = v;
      pps_pkg::PPS_PORT_B: ext_b[4:0] = v[4:0];
      pps_pkg::PPS_PORT_C: ext_c = v;
      pps_pkg::PPS_PORT_D: ext_d[1:0] = v[1:0];
      default: ext_e[1:0] = v[1:0];
    endcase
  endtask : set_ext

  task automatic reset_check(input int cycles);
    reset_n = 1'b0;
    repeat (cycles) @(negedge clk_sys);
    check({port_a_oe, port_c_oe}, 16'h0000, "oe in reset");
    check({port_b_oe, port_d_oe, port_e_oe, port_g_oe}, 16'h0000, "oe in reset");
    reset_n = 1'b1;
    repeat (2) @(negedge clk_sys);
    check({port_a_oe, port_c_oe}, 16'h0000, "oe after reset");
    check({port_b_oe, port_d_oe, port_e_oe, port_g_oe}, 16'h0000, "oe released");
    check({12'h000, port_f_o}, 16'h0000, "port_f after reset");
  endtask : reset_check

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_bidir;
    pps_pkg::pps_port_t p;
    logic [7:0] dir, dat, ev, m;
    logic [23:0] ob;
    for (int i = 0; i < 5; i++) begin
      for (int k = 0; k < 2; k++) begin
        p   = pps_pkg::pps_port_t'(i);
        dir = k ? 8'h5A : 8'hA5;
        dat = k ? 8'hFF : 8'h3C;
        ev  = k ? 8'h00 : 8'h96;
        m   = 8'hFF >> (8 - wid(p));
        set_ext(p, ev);
        wr_send(1'b1, p, dir);
        wr_send(1'b0, p, dat);
        wr_end(5);
        ob = obs(p);
        check(ob[15:8], dir & m, "direction");
        check(ob[23:16] & dir & m, dat & dir & m, "drive value");
        check(ob[7:0] & m, ((dat & dir) | (ev & ~dir)) & m, "read-back");
      end
    end
    $display("test bidirectional ports done");
  endtask : t_bidir

  task automatic t_upper_pwm;
    wr_send(1'b1, pps_pkg::PPS_PORT_A, 8'h0F);
    wr_send(1'b0, pps_pkg::PPS_PORT_A, 8'h50);
    wr_end(0);
    upper_pwm_en = 1'b1;
    upper_pwm_outputs = 4'hA;
    repeat (3) @(negedge clk_sys);
    check({port_a_o[3:0], port_a_oe}, 16'h0A0F, "pwm on port_a");
    upper_pwm_en = 1'b0;
    repeat (2) @(negedge clk_sys);
    check({port_a_o[3:0], port_a_oe}, 16'h000F, "port_a released");
    $display("test upper pwm done");
  endtask : t_upper_pwm

  task automatic t_serial;
    wr_send(1'b1, pps_pkg::PPS_PORT_E, 8'h00);
    wr_end(2);
    serial_en = 1'b1;
    for (int k = 0; k < 2; k++) begin
      serial_out_val = (k == 0);
      serial_clk_val = (k == 1);
      repeat (2) @(negedge clk_sys);
      check({port_e_oe, port_e_o}, k ? 16'h000E : 16'h000D, "serial pins");
    end
    serial_en = 1'b0;
    repeat (2) @(negedge clk_sys);
    check({14'h0000, port_e_oe}, 16'h0000, "serial released");
    $display("test serial pins done");
  endtask : t_serial

  task automatic t_inputs;
    for (int k = 0; k < 2; k++) begin
      ext_b[7:5] = k ? 3'b010 : 3'b101;
      ext_d[5:2] = k ? 4'b0101 : 4'b1010;
      ext_e[2]   = k ? 1'b0 : 1'b1;
      repeat (3) @(negedge clk_sys);
      check({6'h00, analog_cmp_inputs, timer_ext_clk, ext_irq_one, ext_irq_two, serial_in_pin},
            k ? 16'h004C : 16'h03B3, "input functions");
      check({port_b_rd[7:5], port_d_rd[5:2], port_e_rd[2]}, k ? 16'h004A : 16'h00B5,
            "input-only read-back");
    end
    $display("test input-only bits done");
  endtask : t_inputs

  task automatic t_out_ports;
    wr_send(1'b0, pps_pkg::PPS_PORT_G, 8'h05);
    wr_send(1'b0, pps_pkg::PPS_PORT_F, 8'h09);
    wr_send(1'b1, pps_pkg::PPS_PORT_G, 8'h00);
    wr_end(2);
    check({port_g_o, port_g_oe, port_f_o}, 16'h00A9, "output latches");
    lower_pwm_en = 4'b0011;
    lower_pwm_outputs = 4'b1110;
    osd_en = 1'b1;
    osd_color_outputs = 4'h6;
    repeat (2) @(negedge clk_sys);
    check({port_g_o, port_g_oe, port_f_o}, 16'h0096, "pwm and osd share");
    osd_en = 1'b0;
    lower_pwm_en = 4'b0000;
    repeat (2) @(negedge clk_sys);
    check({port_g_oe, port_f_o}, 16'h00A9, "latches back");
    $display("test output-only ports done");
  endtask : t_out_ports

  // ----------------------------------------------------------------
  // Sequence and verdict
  // ----------------------------------------------------------------
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run

  initial begin
    reset_check(16);
    t_bidir();
    t_upper_pwm();
    t_serial();
    t_inputs();
    t_out_ports();
    reset_check(2);
    $display("test mid-run reset done");
    complete_run();
  end

  // Whole sequence needs about 140 cycles
  initial begin
    repeat (5000) @(posedge clk_sys);
    error_cnt++;
    complete_run();
  end
endmodule : port_pin_sharing_bench
